// ==== pkg/cps_pkg.sv ====
// clock pin function select: register map, field codes and reset values
// assumes an APB slave on a single 250 MHz clock with asynchronous low reset
package cps_pkg;

  // ***********************************************************
  // bus geometry
  // ***********************************************************
  localparam int CPS_ADDR_W = 18;
  localparam int CPS_DATA_W = 32;
  localparam int CPS_NREG = 12;

  // ***********************************************************
  // register indices; byte address is four times the index
  // ***********************************************************
  localparam logic [15:0] CPS_IDX_PORT_A_DATA = 16'hF250;
  localparam logic [15:0] CPS_IDX_PORT_A_DIRECTION = 16'hF251;
  localparam logic [15:0] CPS_IDX_PORT_A_CONTROL_LOW = 16'hF252;
  localparam logic [15:0] CPS_IDX_PORT_A_CONTROL_HIGH = 16'hF253;
  localparam logic [15:0] CPS_IDX_PORT_A_MODE_LOW = 16'hF254;
  localparam logic [15:0] CPS_IDX_PORT_A_MODE_HIGH = 16'hF255;
  localparam logic [15:0] CPS_IDX_PORT_B_DATA = 16'hF258;
  localparam logic [15:0] CPS_IDX_PORT_B_DIRECTION = 16'hF259;
  localparam logic [15:0] CPS_IDX_PORT_B_CONTROL_LOW = 16'hF25A;
  localparam logic [15:0] CPS_IDX_PORT_B_CONTROL_HIGH = 16'hF25B;
  localparam logic [15:0] CPS_IDX_PORT_B_MODE_LOW = 16'hF25C;
  localparam logic [15:0] CPS_IDX_PORT_B_MODE_HIGH = 16'hF25D;
  localparam logic [15:0] CPS_IDX_CLOCK_ROUTE_STATUS = 16'hF25E;

  // storage slot of each register, in the order of the table above
  typedef enum logic [3:0] {
    CPS_R_PA_DATA = 4'b0000,
    CPS_R_PA_DIR = 4'b0001,
    CPS_R_PA_CTL_LO = 4'b0010,
    CPS_R_PA_CTL_HI = 4'b0011,
    CPS_R_PA_MOD_LO = 4'b0100,
    CPS_R_PA_MOD_HI = 4'b0101,
    CPS_R_PB_DATA = 4'b0110,
    CPS_R_PB_DIR = 4'b0111,
    CPS_R_PB_CTL_LO = 4'b1000,
    CPS_R_PB_CTL_HI = 4'b1001,
    CPS_R_PB_MOD_LO = 4'b1010,
    CPS_R_PB_MOD_HI = 4'b1011
  } cps_reg_t;

  localparam logic [15:0] CPS_IDX [CPS_NREG] = '{
    CPS_IDX_PORT_A_DATA, CPS_IDX_PORT_A_DIRECTION, CPS_IDX_PORT_A_CONTROL_LOW,
    CPS_IDX_PORT_A_CONTROL_HIGH, CPS_IDX_PORT_A_MODE_LOW, CPS_IDX_PORT_A_MODE_HIGH,
    CPS_IDX_PORT_B_DATA, CPS_IDX_PORT_B_DIRECTION, CPS_IDX_PORT_B_CONTROL_LOW,
    CPS_IDX_PORT_B_CONTROL_HIGH, CPS_IDX_PORT_B_MODE_LOW, CPS_IDX_PORT_B_MODE_HIGH
  };

  // ***********************************************************
  // port widths, special lines, field codes
  // ***********************************************************
  localparam int CPS_PA_W = 3;
  localparam int CPS_PB_W = 8;
  localparam int CPS_PA_NREG = 6;
  localparam int CPS_PA_CLK_LINE = 2;
  localparam int CPS_PB_OUT_LINE = 0;
  localparam int CPS_PB_CLK_LINE = 6;
  localparam logic [7:0] CPS_REG_RST = 8'h00;
  localparam logic [1:0] CPS_MODE_TERTIARY = 2'b10;
  localparam logic [1:0] CPS_CTRL_HIZ = 2'b00;
  localparam logic [1:0] CPS_CTRL_CMOS = 2'b11;
  localparam logic DIR_OUT = 1'b0;
  localparam logic DIR_IN = 1'b1;

  // status register fields
  localparam int CPS_ST_FAST_OUT = 0;
  localparam int CPS_ST_PA2_IN = 1;
  localparam int CPS_ST_PB6_IN = 2;
  localparam int CPS_ST_SRC_PB6 = 3;
  localparam int CPS_ST_W = 4;

endpackage

// ==== logic/cps_reg.sv ====
// cps_reg: one software register of configurable width, zero-extended to a byte
// assumes the write strobe is a single-cycle pulse from the bus slave
`timescale 1ns/100ps
module cps_reg
  import cps_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write side
  input wire logic we,
  input wire logic [7:0] wdata,
  // stored value
  output logic [7:0] q
);

  logic [WIDTH-1:0] val_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_q <= CPS_REG_RST[WIDTH-1:0];
    end else if (we) begin
      val_q <= wdata[WIDTH-1:0];
    end
  end

  generate
    if (WIDTH < 8) begin : g_pad
      assign q = {{(8 - WIDTH){1'b0}}, val_q};
    end else begin : g_full
      assign q = val_q;
    end
  endgenerate

endmodule

// ==== logic/cps_top.sv ====
// cps_top: port A/B pin function select with high-speed clock out and clock in
// assumes APB master on pclk; pin inputs already synchronous to pclk
//
// Function
// - PB line0 mode bits 1/0 select high-speed clock as its tertiary function
// - PB line0 drives as CMOS output when both control bits 1, direction 0
// - PB line0 data bit has no effect while clock output is active
// - PA line2 mode bits 1/0 select it as external clock input
// - PA line2 is input when both control bits 0 and direction 1
// - PA line2 data bit has no effect on the clock input function
// - when PA line2 and PB line6 both are clock inputs, PA line2 wins
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module cps_top
  import cps_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [CPS_ADDR_W-1:0] paddr,
  input wire logic [CPS_DATA_W-1:0] pwdata,
  output logic [CPS_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // internal high-speed clock to be routed out
  input wire logic high_speed_clock,
  // port A pins
  input wire logic [CPS_PA_W-1:0] porta_in,
  output logic [CPS_PA_W-1:0] porta_out,
  output logic [CPS_PA_W-1:0] porta_oe,
  // port B pins
  input wire logic [CPS_PB_W-1:0] portb_in,
  output logic [CPS_PB_W-1:0] portb_out,
  output logic [CPS_PB_W-1:0] portb_oe,
  // external clock toward the clock generator
  output logic external_clock_input,
  output logic ext_clock_valid,
  output logic ext_clock_from_pb6
);

  // ***********************************************************
  // register storage
  // ***********************************************************
  logic [7:0] reg_q [CPS_NREG];
  logic [CPS_NREG-1:0] reg_we;
  logic [CPS_NREG-1:0] reg_hit;
  logic [7:0] wbyte;

  assign wbyte = pwdata[7:0];

  genvar gi;
  generate
    for (gi = 0; gi < CPS_NREG; gi++) begin : g_reg
      localparam int W = (gi < CPS_PA_NREG) ? CPS_PA_W : CPS_PB_W;
      assign reg_hit[gi] = (paddr[CPS_ADDR_W-1:2] == CPS_IDX[gi]);
      cps_reg #(.WIDTH(W)) u_reg (
        .pclk(pclk),
        .presetn(presetn),
        .we(reg_we[gi]),
        .wdata(wbyte),
        .q(reg_q[gi])
      );
    end
  endgenerate

  wire [CPS_PA_W-1:0] pa_data = reg_q[CPS_R_PA_DATA][CPS_PA_W-1:0];
  wire [CPS_PA_W-1:0] pa_dir = reg_q[CPS_R_PA_DIR][CPS_PA_W-1:0];
  wire [CPS_PA_W-1:0] pa_c0 = reg_q[CPS_R_PA_CTL_LO][CPS_PA_W-1:0];
  wire [CPS_PA_W-1:0] pa_c1 = reg_q[CPS_R_PA_CTL_HI][CPS_PA_W-1:0];
  wire [CPS_PA_W-1:0] pa_m0 = reg_q[CPS_R_PA_MOD_LO][CPS_PA_W-1:0];
  wire [CPS_PA_W-1:0] pa_m1 = reg_q[CPS_R_PA_MOD_HI][CPS_PA_W-1:0];
  wire [CPS_PB_W-1:0] pb_data = reg_q[CPS_R_PB_DATA];
  wire [CPS_PB_W-1:0] pb_dir = reg_q[CPS_R_PB_DIR];
  wire [CPS_PB_W-1:0] pb_c0 = reg_q[CPS_R_PB_CTL_LO];
  wire [CPS_PB_W-1:0] pb_c1 = reg_q[CPS_R_PB_CTL_HI];
  wire [CPS_PB_W-1:0] pb_m0 = reg_q[CPS_R_PB_MOD_LO];
  wire [CPS_PB_W-1:0] pb_m1 = reg_q[CPS_R_PB_MOD_HI];

  // ***********************************************************
  // clock function decode
  // ***********************************************************
  wire portb_line0_mode_hi = pb_m1[CPS_PB_OUT_LINE];
  wire portb_line0_mode_lo = pb_m0[CPS_PB_OUT_LINE];
  wire portb_line0_ctrl_hi = pb_c1[CPS_PB_OUT_LINE];
  wire portb_line0_ctrl_lo = pb_c0[CPS_PB_OUT_LINE];
  wire portb_line0_direction = pb_dir[CPS_PB_OUT_LINE];
  wire portb_line0_data = pb_data[CPS_PB_OUT_LINE];
  wire porta_line2_mode_hi = pa_m1[CPS_PA_CLK_LINE];
  wire porta_line2_mode_lo = pa_m0[CPS_PA_CLK_LINE];
  wire porta_line2_ctrl_hi = pa_c1[CPS_PA_CLK_LINE];
  wire porta_line2_ctrl_lo = pa_c0[CPS_PA_CLK_LINE];
  wire porta_line2_direction = pa_dir[CPS_PA_CLK_LINE];
  wire porta_line2_data = pa_data[CPS_PA_CLK_LINE];

  // tertiary selection of the clock lines
  wire pb0_tert = ({portb_line0_mode_hi, portb_line0_mode_lo} == CPS_MODE_TERTIARY);
  wire pb0_cmos = ({portb_line0_ctrl_hi, portb_line0_ctrl_lo} == CPS_CTRL_CMOS)
    && (portb_line0_direction == DIR_OUT);
  wire fast_out_act = pb0_tert && pb0_cmos;
  wire pa2_tert = ({porta_line2_mode_hi, porta_line2_mode_lo} == CPS_MODE_TERTIARY);
  wire pa2_input = ({porta_line2_ctrl_hi, porta_line2_ctrl_lo} == CPS_CTRL_HIZ)
    && (porta_line2_direction == DIR_IN);
  wire pa2_clk_act = pa2_tert && pa2_input;
  wire pb6_clk_act = ({pb_m1[CPS_PB_CLK_LINE], pb_m0[CPS_PB_CLK_LINE]} == CPS_MODE_TERTIARY)
    && ({pb_c1[CPS_PB_CLK_LINE], pb_c0[CPS_PB_CLK_LINE]} == CPS_CTRL_HIZ)
    && (pb_dir[CPS_PB_CLK_LINE] == DIR_IN);
  wire clk_from_pb6 = pb6_clk_act && !pa2_clk_act;
  wire clk_valid_d = pa2_clk_act || pb6_clk_act;
  wire clk_pin_d = pa2_clk_act ? porta_in[CPS_PA_CLK_LINE] :
    (pb6_clk_act ? portb_in[CPS_PB_CLK_LINE] : 1'b0);

  // ***********************************************************
  // ordinary port drive
  // ***********************************************************
  // returns {oe, out}: hi-z, open drain (pull low only) or cmos
  function automatic logic [1:0] line_drive(input logic dir, input logic c1,
      input logic c0, input logic data);
    logic [1:0] r;
    r = 2'b00;
    if (dir == DIR_OUT) begin
      case ({c1, c0})
        CPS_CTRL_HIZ: r = 2'b00;
        CPS_CTRL_CMOS: r = {1'b1, data};
        default: r = {~data, 1'b0};
      endcase
    end
    return r;
  endfunction

  logic [CPS_PA_W-1:0] pa_out_d;
  logic [CPS_PA_W-1:0] pa_oe_d;
  logic [CPS_PB_W-1:0] pb_out_d;
  logic [CPS_PB_W-1:0] pb_oe_d;

  always_comb begin
    logic [1:0] drv;
    drv = 2'b00;
    for (int i = 0; i < CPS_PA_W; i++) begin
      drv = line_drive(pa_dir[i], pa_c1[i], pa_c0[i], pa_data[i]);
      pa_oe_d[i] = drv[1];
      pa_out_d[i] = drv[0];
    end
    for (int i = 0; i < CPS_PB_W; i++) begin
      drv = line_drive(pb_dir[i], pb_c1[i], pb_c0[i], pb_data[i]);
      pb_oe_d[i] = drv[1];
      pb_out_d[i] = drv[0];
    end
    if (fast_out_act) begin
      // data bit is bypassed; the line carries the clock
      pb_oe_d[CPS_PB_OUT_LINE] = 1'b1;
      pb_out_d[CPS_PB_OUT_LINE] = high_speed_clock;
    end
  end

  // ***********************************************************
  // pin and clock registers
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      porta_out <= '0;
      porta_oe <= '0;
      portb_out <= '0;
      portb_oe <= '0;
      external_clock_input <= 1'b0;
      ext_clock_valid <= 1'b0;
      ext_clock_from_pb6 <= 1'b0;
    end else begin
      porta_out <= pa_out_d;
      porta_oe <= pa_oe_d;
      portb_out <= pb_out_d;
      portb_oe <= pb_oe_d;
      external_clock_input <= clk_pin_d;
      ext_clock_valid <= clk_valid_d;
      ext_clock_from_pb6 <= clk_from_pb6;
    end
  end

  // ***********************************************************
  // route status
  // ***********************************************************
  logic [CPS_ST_W-1:0] status_q;
  logic [CPS_ST_W-1:0] status_d;

  always_comb begin
    status_d = '0;
    status_d[CPS_ST_FAST_OUT] = fast_out_act;
    status_d[CPS_ST_PA2_IN] = pa2_clk_act;
    status_d[CPS_ST_PB6_IN] = pb6_clk_act;
    status_d[CPS_ST_SRC_PB6] = clk_from_pb6;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // ***********************************************************
  // apb slave: one wait state, answer on the second access cycle
  // ***********************************************************
  wire acc_ph = psel && penable;
  wire acc_done = acc_ph && pready;
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_status = (paddr[CPS_ADDR_W-1:2] == CPS_IDX_CLOCK_ROUTE_STATUS);
  wire mapped = aligned && ((|reg_hit) || hit_status);

  assign reg_we = (acc_done && pwrite && aligned) ? reg_hit : '0;

  logic [7:0] rd_byte;

  // port A data reads the pin on input lines, the latch on output lines
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < CPS_NREG; i++) begin
      if (reg_hit[i]) begin
        rd_byte = reg_q[i];
      end
    end
    if (reg_hit[CPS_R_PA_DATA]) begin
      rd_byte = {{(8 - CPS_PA_W){1'b0}}, (pa_dir & porta_in) | (~pa_dir & pa_data)};
    end
    if (hit_status) begin
      rd_byte = {{(8 - CPS_ST_W){1'b0}}, status_q};
    end
  end

  wire [CPS_DATA_W-1:0] rd_word = mapped ? {{(CPS_DATA_W - 8){1'b0}}, rd_byte} : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= acc_ph && !pready;
      pslverr <= acc_ph && !pready && !mapped;
      prdata <= (acc_ph && !pready && !pwrite) ? rd_word : '0;
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fast_clock_route: assert property (fast_out_act |=>
    portb_out[CPS_PB_OUT_LINE] == $past(high_speed_clock))
    else $error("fast clock not routed to port B line 0");
  a_fast_cmos_drive: assert property (fast_out_act |=>
    portb_oe[CPS_PB_OUT_LINE])
    else $error("port B line 0 not driven while clock out");
  a_fast_data_ignored: assert property (
    (fast_out_act && portb_line0_data != high_speed_clock) |=>
    portb_out[CPS_PB_OUT_LINE] != $past(portb_line0_data))
    else $error("port B data bit leaked onto clock output");
  a_external_clock_input_taken: assert property (pa2_clk_act |=>
    ext_clock_valid && external_clock_input == $past(porta_in[CPS_PA_CLK_LINE]))
    else $error("port A line 2 clock not taken");
  a_external_clock_input_is_input: assert property (pa2_clk_act |=>
    !porta_oe[CPS_PA_CLK_LINE])
    else $error("port A line 2 driven while clock input");
  a_external_clock_input_data_ignored: assert property (
    (pa2_clk_act && porta_in[CPS_PA_CLK_LINE] != porta_line2_data) |=>
    external_clock_input != $past(porta_line2_data))
    else $error("port A data bit reached clock input");
  a_external_clock_input_priority: assert property ((pa2_clk_act && pb6_clk_act) |=>
    !ext_clock_from_pb6 && external_clock_input == $past(porta_in[CPS_PA_CLK_LINE]))
    else $error("port B line 6 won over port A line 2");
  a_ordinary_port: assert property (
    (!fast_out_act && pb0_cmos) |=>
    portb_out[CPS_PB_OUT_LINE] == $past(portb_line0_data))
    else $error("port B line 0 lost ordinary function");
  a_no_clock_idle: assert property ((!pa2_clk_act && !pb6_clk_act) |=>
    !ext_clock_valid && !external_clock_input)
    else $error("clock input active without clock setting");
  a_apb_one_wait: assert property ((acc_ph && !pready) |=> pready ##1 !pready)
    else $error("apb answer not on second access cycle");

  c_fast_out: cover property (fast_out_act ##1 portb_oe[CPS_PB_OUT_LINE]);
  c_pa2_clock: cover property (pa2_clk_act && !pb6_clk_act);
  c_both_clock: cover property (pa2_clk_act && pb6_clk_act);
  c_unmapped: cover property (pready && pslverr);

endmodule

// ==== tb/cps_board.sv ====
// cps_board: board model, an external clock source on port A line 2 and port B line 6
// assumes pins the block does not drive are pulled up; idle sources stand at the pull-up
`timescale 1ns/100ps
module cps_board
  import cps_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // source enables
  input wire logic run_a,
  input wire logic run_b,
  // pin drive from the block
  input wire logic [CPS_PA_W-1:0] porta_out,
  input wire logic [CPS_PA_W-1:0] porta_oe,
  input wire logic [CPS_PB_W-1:0] portb_out,
  input wire logic [CPS_PB_W-1:0] portb_oe,
  // pin levels seen by the block
  output logic [CPS_PA_W-1:0] porta_in,
  output logic [CPS_PB_W-1:0] portb_in
);
  logic [2:0] cnt_q;
  logic clk_a;
  logic clk_b;

  // ***********************************************************
  // two sources with different patterns so they can be told apart
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  assign clk_a = run_a ? (cnt_q[0] ^ cnt_q[2]) : 1'b1;
  assign clk_b = run_b ? cnt_q[2] : 1'b1;

  // ***********************************************************
  // wire levels: block drive wins, else source or pull-up
  // ***********************************************************
  always_comb begin
    for (int i = 0; i < CPS_PA_W; i++) begin
      porta_in[i] = porta_oe[i] ? porta_out[i] : 1'b1;
    end
    for (int i = 0; i < CPS_PB_W; i++) begin
      portb_in[i] = portb_oe[i] ? portb_out[i] : 1'b1;
    end
    if (!porta_oe[2]) begin
      porta_in[2] = clk_a;
    end
    if (!portb_oe[6]) begin
      portb_in[6] = clk_b;
    end
  end
endmodule

// ==== tb/cps_top_test.sv ====
// cps_top_test: self-checking bench for the clock pin function select block
// assumes the board model cps_board and the package cps_pkg
`timescale 1ns/100ps
module cps_top_test
  import cps_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [CPS_ADDR_W-1:0] paddr;
  logic [CPS_DATA_W-1:0] pwdata, prdata;
  logic high_speed_clock, run_a, run_b, external_clock_input;
  logic ext_clock_valid, ext_clock_from_pb6;
  logic [CPS_PA_W-1:0] porta_in, porta_out, porta_oe;
  logic [CPS_PB_W-1:0] portb_in, portb_out, portb_oe;
  logic [1:0] hs_cnt;
  int bad_count, checks_done;

  cps_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .high_speed_clock(high_speed_clock), .porta_in(porta_in),
    .porta_out(porta_out), .porta_oe(porta_oe), .portb_in(portb_in),
    .portb_out(portb_out), .portb_oe(portb_oe),
    .external_clock_input(external_clock_input), .ext_clock_valid(ext_clock_valid),
    .ext_clock_from_pb6(ext_clock_from_pb6));

  cps_board u_board (.pclk(pclk), .presetn(presetn), .run_a(run_a), .run_b(run_b),
    .porta_out(porta_out), .porta_oe(porta_oe), .portb_out(portb_out),
    .portb_oe(portb_oe), .porta_in(porta_in), .portb_in(portb_in));

  // ***********************************************************
  // clock, fast clock pattern 0011, watchdog
  // ***********************************************************
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    hs_cnt <= hs_cnt + 2'h1;
    high_speed_clock <= hs_cnt[1];
  end
  initial begin
    #40000;
    bad_count++;
    results();
  end

  // ***********************************************************
  // shared tasks
  // ***********************************************************
  task automatic results();
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until the rising edge that sees pready; answer taken at that edge
  task automatic apb(input logic wr_en, input logic [15:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, wd, rd, err);
    check({31'h0, err}, 32'h0);
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 8'h00, rd, err);
    check(rd, exp);
    check({31'h0, err}, {31'h0, experr});
  endtask

  // output follows its source pin one cycle late: 0 fast clock, 1 line A2, 2 line B6
  task automatic follow(input int which);
    logic prev, cur, seen;
    repeat (2) @(negedge pclk);
    for (int i = 0; i < 9; i++) begin
      @(negedge pclk);
      cur = (which == 0) ? high_speed_clock : (which == 1) ? porta_in[2] : portb_in[6];
      seen = (which == 0) ? portb_out[0] : external_clock_input;
      if (i > 0) begin
        check({31'h0, seen}, {31'h0, prev});
      end
      prev = cur;
    end
  endtask

  // ***********************************************************
  // scenarios
  // ***********************************************************
  task automatic t_reset();
    for (int i = 0; i < CPS_NREG; i++) begin
      rdc(CPS_IDX[i], 32'h0, 1'b0);
    end
    rdc(16'hF260, 32'h0, 1'b1);
    wr(CPS_IDX_PORT_A_DATA, 8'hFF);
    rdc(CPS_IDX_PORT_A_DATA, 32'h07, 1'b0);
    // lines 0 and 1 as cmos outputs, then open drain releasing a high
    wr(CPS_IDX_PORT_A_CONTROL_HIGH, 8'h03);
    wr(CPS_IDX_PORT_A_CONTROL_LOW, 8'h03);
    repeat (2) @(negedge pclk);
    check({26'h0, porta_oe, porta_out}, 32'h1B);
    wr(CPS_IDX_PORT_A_CONTROL_HIGH, 8'h00);
    repeat (2) @(negedge pclk);
    check({26'h0, porta_oe, porta_out}, 32'h0);
    wr(CPS_IDX_PORT_A_CONTROL_LOW, 8'h00);
    wr(CPS_IDX_PORT_A_DATA, 8'h00);
    @(negedge pclk);
    check({porta_oe, portb_oe, ext_clock_valid}, 32'h0);
  endtask

  task automatic t_clk_out();
    wr(CPS_IDX_PORT_B_MODE_HIGH, 8'h01);
    wr(CPS_IDX_PORT_B_CONTROL_HIGH, 8'h01);
    wr(CPS_IDX_PORT_B_CONTROL_LOW, 8'h01);
    wr(CPS_IDX_PORT_B_DATA, 8'h01);
    follow(0);
    check({24'h0, portb_oe}, 32'h01);
    wr(CPS_IDX_PORT_B_DATA, 8'h00);
    follow(0);
    rdc(CPS_IDX_CLOCK_ROUTE_STATUS, 32'h01, 1'b0);
    wr(CPS_IDX_PORT_B_MODE_LOW, 8'h01);
    repeat (3) @(negedge pclk);
    check({31'h0, portb_out[0]}, 32'h0);
    repeat (2) @(negedge pclk);
    check({31'h0, portb_out[0]}, 32'h0);
    wr(CPS_IDX_PORT_B_MODE_LOW, 8'h00);
    wr(CPS_IDX_PORT_B_DIRECTION, 8'h01);
    repeat (3) @(negedge pclk);
    check({31'h0, portb_oe[0]}, 32'h0);
  endtask

  task automatic t_clk_in();
    @(posedge pclk);
    run_a <= 1'b1;
    run_b <= 1'b1;
    wr(CPS_IDX_PORT_A_MODE_HIGH, 8'h04);
    wr(CPS_IDX_PORT_A_DIRECTION, 8'h04);
    wr(CPS_IDX_PORT_A_DATA, 8'h04);
    follow(1);
    check({porta_oe, ext_clock_valid, ext_clock_from_pb6}, 32'h02);
    wr(CPS_IDX_PORT_A_DATA, 8'h00);
    follow(1);
    wr(CPS_IDX_PORT_B_MODE_HIGH, 8'h40);
    wr(CPS_IDX_PORT_B_CONTROL_HIGH, 8'h00);
    wr(CPS_IDX_PORT_B_CONTROL_LOW, 8'h00);
    wr(CPS_IDX_PORT_B_DIRECTION, 8'h40);
    follow(1);
    check({31'h0, ext_clock_from_pb6}, 32'h0);
    wr(CPS_IDX_PORT_A_DIRECTION, 8'h00);
    follow(2);
    check({30'h0, ext_clock_valid, ext_clock_from_pb6}, 32'h3);
    wr(CPS_IDX_PORT_B_CONTROL_LOW, 8'h40);
    repeat (3) @(negedge pclk);
    check({30'h0, ext_clock_valid, external_clock_input}, 32'h0);
    repeat (3) @(negedge pclk);
    check({31'h0, external_clock_input}, 32'h0);
  endtask

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    high_speed_clock = 1'b0;
    hs_cnt = 2'h0;
    run_a = 1'b0;
    run_b = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_clk_out();
    t_clk_in();
    results();
  end
endmodule
